// ### hsu_map.svh
// register offsets, bit positions, reset values and sizes of the packet status unit
`ifndef HSU_MAP_SVH
`define HSU_MAP_SVH

// register offsets on the parallel control port
`define HSU_ADDR_STATUS   8'hB1
`define HSU_ADDR_MASK     8'hB2
`define HSU_ADDR_INFO     8'hB3

// packet_ctrl_status / packet_ctrl_irq_mask bit positions
`define HSU_ST_RX_END     6
`define HSU_ST_RX_START   5
`define HSU_ST_RX_HALF    4
`define HSU_ST_RX_NEMPTY  3
`define HSU_ST_TX_HALF    2
`define HSU_ST_TX_NFULL   1
`define HSU_ST_TX_END     0

// receive_packet_info bit positions
`define HSU_IN_ABORT      7
`define HSU_IN_CRC_ERR    6
`define HSU_IN_OVERRUN    5
`define HSU_IN_VALID      4
`define HSU_IN_EMPTY      3
`define HSU_IN_PKT_OK     2
`define HSU_IN_CLOSE      1
`define HSU_IN_OPEN       0

// byte tag layout kept per receive fifo entry
`define HSU_TAG_OK        2
`define HSU_TAG_LAST      1
`define HSU_TAG_FIRST     0
`define HSU_TAG_W         3

// implemented bits and reset values
`define HSU_MASK_USED     8'h7F
`define HSU_MASK_RESET    8'h00
`define HSU_BYTE_ZERO     8'h00

// fifo size and abort run length
`define HSU_FIFO_DEPTH    64
`define HSU_ABORT_ONES    3'h7

`endif

// ### hsu_pkg.sv
// types shared by the packet status unit
`default_nettype none

package hsu_pkg;

    typedef logic [7:0] hsu_byte_t;     // one register byte

    // per-byte receive tag
    typedef struct packed {
        logic ok;                        // last byte of a good packet
        logic last;                      // closing byte
        logic first;                     // opening byte
    } hsu_tag_s;

endpackage

`default_nettype wire

// ### hsu_tag_if.sv
// carrier between the status unit and its receive tag memory
`timescale 1ns/1ns
`default_nettype none

interface hsu_tag_if #(
    parameter int AW = 6,
    parameter int DW = 3
) ();
    logic          wr_en;    // write strobe
    logic [AW-1:0] wr_addr;  // write slot
    logic [DW-1:0] wr_data;  // tag written
    logic [AW-1:0] rd_addr;  // slot to read next cycle
    logic [DW-1:0] rd_data;  // registered tag

    modport ctrl (output wr_en, output wr_addr, output wr_data, output rd_addr, input rd_data);
    modport mem  (input wr_en, input wr_addr, input wr_data, input rd_addr, output rd_data);
endinterface

`default_nettype wire

// ### hsu_tag_mem.sv
// small tag memory with registered read and write-through bypass
`timescale 1ns/1ns
`default_nettype none

module hsu_tag_mem #(
    parameter int AW = 6,
    parameter int DW = 3
) (
    // clock
    input  wire logic clock_i,
    // tag port
    hsu_tag_if.mem    tag
);

    // ==========================================================
    // storage
    logic [DW-1:0] mem [0:(1<<AW)-1];  // tag array
    logic [DW-1:0] next_rd_data;       // read value for next cycle

    // pick stored tag, or the one being written to the same slot
    always_comb begin
        if (tag.wr_en && (tag.wr_addr == tag.rd_addr)) begin
            next_rd_data = tag.wr_data;
        end else begin
            next_rd_data = mem[tag.rd_addr];
        end
    end

    // array write and read register
    always_ff @(posedge clock_i) begin
        if (tag.wr_en) begin
            mem[tag.wr_addr] <= tag.wr_data;
        end
        tag.rd_data <= next_rd_data;
    end

endmodule

`default_nettype wire

// ### hsu_status_unit.sv
// packet controller status, interrupt mask and receive information registers
//
// How it works
// R01: packet end on good close or fault
// R02: packet start on opening byte detect
// R03: receive half full above half depth
// R04: receive not empty while byte stored
// R05: transmit half empty below half depth
// R06: transmit not full while space free
// R07: transmit message end when send finishes
// R08: end/start/tx-end flags latch, clear on read
// R09: mask bit 1 enables, 0 blocks interrupt
// R10: abort flag after seven ones in row
// R11: crc error flag on checksum mismatch
// R12: overrun flag on push into full fifo
// R13: valid message flag on checked good packet
// R14: receive empty is live, unlatched
// R15: packet ok tags last byte of good packet
// R16: closing byte tags last byte of packet
// R17: opening byte tags first byte of packet
// R18: info flags latch, clear on read
// R19: interrupt low on unmasked pending event
// R20: interrupt releases high once nothing pending
`timescale 1ns/1ns
`default_nettype none
`include "hsu_map.svh"

module hsu_status_unit
    import hsu_pkg::*;
#(
    parameter int DEPTH = `HSU_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    // parallel control port
    input  wire logic [7:0] addr_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] wdata_i,
    output logic      [7:0] rdata_o,
    output logic            int_n_o,
    // receive packet controller
    input  wire logic       rx_bit_i,
    input  wire logic       rx_bit_valid_i,
    input  wire logic       rx_opening_i,
    input  wire logic       rx_push_i,
    input  wire logic       rx_push_last_i,
    input  wire logic       rx_crc_match_i,
    input  wire logic       rx_pop_i,
    // transmit packet controller
    input  wire logic       tx_push_i,
    input  wire logic       tx_pop_i,
    input  wire logic       tx_msg_done_i
);

    // ==========================================================
    // sizes
    localparam int AW = $clog2(DEPTH);        // pointer width
    localparam int CW = $clog2(DEPTH + 1);    // count width
    localparam logic [CW-1:0] FULL_CNT = CW'(DEPTH);
    localparam logic [CW-1:0] HALF_CNT = CW'(DEPTH / 2);
    localparam logic [CW-1:0] ONE_CNT  = CW'(1);
    localparam logic [AW-1:0] ONE_PTR  = AW'(1);

    // ==========================================================
    // state
    hsu_byte_t     lat_stat;       // latched status events
    hsu_byte_t     lat_info;       // latched receive info events
    hsu_byte_t     mask;           // interrupt mask
    logic [CW-1:0] rx_cnt;         // receive fifo occupancy
    logic [CW-1:0] tx_cnt;         // transmit fifo occupancy
    logic [AW-1:0] rx_wr_ptr;      // receive tag write slot
    logic [AW-1:0] rx_rd_ptr;      // receive tag head slot
    logic [2:0]    ones_cnt;       // run of ones, saturating
    logic          pend_first;     // next push is an opening byte
    logic          pkt_bad;        // current packet saw a fault

    hsu_byte_t     next_lat_stat;
    hsu_byte_t     next_lat_info;
    hsu_byte_t     next_mask;
    logic [CW-1:0] next_rx_cnt;
    logic [CW-1:0] next_tx_cnt;
    logic [AW-1:0] next_rx_wr_ptr;
    logic [AW-1:0] next_rx_rd_ptr;
    logic [2:0]    next_ones_cnt;
    logic          next_pend_first;
    logic          next_pkt_bad;
    hsu_byte_t     next_rdata;
    logic          next_int_n;

    // event terms
    logic          ev_abort;       // seventh one in a row
    logic          ev_ovr;         // push refused, fifo full
    logic          rx_take;        // push accepted
    logic          rx_give;        // pop accepted
    logic          ev_close;       // closing byte with crc done
    logic          ev_crc_err;     // closing byte, crc mismatch
    logic          ev_valid;       // closing byte of good packet
    hsu_tag_s      wr_tag;         // tag for pushed byte
    hsu_tag_s      head_tag;       // tag of readable byte
    hsu_byte_t     stat_view;      // status as read now
    hsu_byte_t     info_view;      // info as read now
    hsu_byte_t     stat_set;       // status set pulses
    hsu_byte_t     info_set;       // info set pulses

    hsu_tag_if #(.AW(AW), .DW(`HSU_TAG_W)) tag_bus ();

    // ==========================================================
    // status register view from latches and fifo levels
    function automatic hsu_byte_t status_of(input hsu_byte_t lat,
                                            input logic [CW-1:0] rc,
                                            input logic [CW-1:0] tc);
        hsu_byte_t v;
        v = `HSU_BYTE_ZERO;
        v[`HSU_ST_RX_END]    = lat[`HSU_ST_RX_END];     // R08
        v[`HSU_ST_RX_START]  = lat[`HSU_ST_RX_START];   // R08
        v[`HSU_ST_TX_END]    = lat[`HSU_ST_TX_END];     // R08
        v[`HSU_ST_RX_HALF]   = (rc > HALF_CNT);         // R03
        v[`HSU_ST_RX_NEMPTY] = (rc != '0);              // R04
        v[`HSU_ST_TX_HALF]   = (tc < HALF_CNT);         // R05
        v[`HSU_ST_TX_NFULL]  = (tc < FULL_CNT);         // R06
        return v;
    endfunction

    // ==========================================================
    // receive tag memory
    hsu_tag_mem #(.AW(AW), .DW(`HSU_TAG_W)) u_tag_mem (
        .clock_i (clock_i),
        .tag     (tag_bus)
    );

    // drive the tag port
    always_comb begin
        tag_bus.wr_en   = rx_take;
        tag_bus.wr_addr = rx_wr_ptr;
        tag_bus.wr_data = wr_tag;
        tag_bus.rd_addr = next_rx_rd_ptr;
    end
    assign head_tag = hsu_tag_s'(tag_bus.rd_data);

    // ==========================================================
    // event detection
    always_comb begin
        // abort: the bit that makes the run reach seven
        ev_abort   = rx_bit_valid_i && rx_bit_i
                     && (ones_cnt == (`HSU_ABORT_ONES - 3'h1));          // R10
        ev_ovr     = rx_push_i && (rx_cnt == FULL_CNT);                  // R12
        rx_take    = rx_push_i && !ev_ovr;
        rx_give    = rx_pop_i && (rx_cnt != '0);
        ev_close   = rx_push_i && rx_push_last_i;
        ev_crc_err = ev_close && !rx_crc_match_i;                        // R11
        ev_valid   = ev_close && rx_crc_match_i && !pkt_bad
                     && !ev_ovr && !ev_abort;                            // R13
        // tag of the byte going into the fifo
        wr_tag.first = pend_first;                                       // R17
        wr_tag.last  = rx_push_last_i;                                   // R16
        wr_tag.ok    = ev_valid;                                         // R15
        // set pulses
        stat_set = `HSU_BYTE_ZERO;
        stat_set[`HSU_ST_RX_END]   = ev_close || ev_crc_err
                                     || ev_ovr || ev_abort;              // R01
        stat_set[`HSU_ST_RX_START] = rx_opening_i;                       // R02
        stat_set[`HSU_ST_TX_END]   = tx_msg_done_i;                      // R07
        info_set = `HSU_BYTE_ZERO;
        info_set[`HSU_IN_ABORT]    = ev_abort;                           // R10
        info_set[`HSU_IN_CRC_ERR]  = ev_crc_err;                         // R11
        info_set[`HSU_IN_OVERRUN]  = ev_ovr;                             // R12
        info_set[`HSU_IN_VALID]    = ev_valid;                           // R13
    end

    // ==========================================================
    // register views
    always_comb begin
        stat_view = status_of(lat_stat, rx_cnt, tx_cnt);
        info_view = `HSU_BYTE_ZERO;
        info_view[`HSU_IN_ABORT]   = lat_info[`HSU_IN_ABORT];            // R18
        info_view[`HSU_IN_CRC_ERR] = lat_info[`HSU_IN_CRC_ERR];          // R18
        info_view[`HSU_IN_OVERRUN] = lat_info[`HSU_IN_OVERRUN];          // R18
        info_view[`HSU_IN_VALID]   = lat_info[`HSU_IN_VALID];            // R18
        info_view[`HSU_IN_EMPTY]   = (rx_cnt == '0);                     // R14
        // head tags only mean something while a byte is held
        info_view[`HSU_IN_PKT_OK]  = head_tag.ok && (rx_cnt != '0);      // R15
        info_view[`HSU_IN_CLOSE]   = head_tag.last && (rx_cnt != '0);    // R16
        info_view[`HSU_IN_OPEN]    = head_tag.first && (rx_cnt != '0);   // R17
    end

    // ==========================================================
    // next state: latches, mask, counts, packet tracking, host port
    always_comb begin
        logic rd_stat;
        logic rd_info;
        rd_stat = rd_i && (addr_i == `HSU_ADDR_STATUS);
        rd_info = rd_i && (addr_i == `HSU_ADDR_INFO);

        // latched flags: a read clears what it returned, a new set wins
        next_lat_stat = lat_stat;
        if (rd_stat) begin
            next_lat_stat = lat_stat & ~stat_view;                       // R08
        end
        next_lat_stat = next_lat_stat | stat_set;
        next_lat_info = lat_info;
        if (rd_info) begin
            next_lat_info = lat_info & ~info_view;                       // R18
        end
        next_lat_info = next_lat_info | info_set;

        // mask register, unused top bit kept zero
        next_mask = mask;
        if (wr_i && (addr_i == `HSU_ADDR_MASK)) begin
            next_mask = wdata_i & `HSU_MASK_USED;                        // R09
        end

        // receive fifo occupancy and pointers
        next_rx_cnt    = rx_cnt;
        next_rx_wr_ptr = rx_wr_ptr;
        next_rx_rd_ptr = rx_rd_ptr;
        if (rx_take) begin
            next_rx_wr_ptr = rx_wr_ptr + ONE_PTR;
        end
        if (rx_give) begin
            next_rx_rd_ptr = rx_rd_ptr + ONE_PTR;
        end
        if (rx_take && !rx_give) begin
            next_rx_cnt = rx_cnt + ONE_CNT;
        end else if (rx_give && !rx_take) begin
            next_rx_cnt = rx_cnt - ONE_CNT;
        end

        // transmit fifo occupancy, out-of-range moves ignored
        next_tx_cnt = tx_cnt;
        if (tx_push_i && !tx_pop_i && (tx_cnt != FULL_CNT)) begin
            next_tx_cnt = tx_cnt + ONE_CNT;
        end else if (tx_pop_i && !tx_push_i && (tx_cnt != '0)) begin
            next_tx_cnt = tx_cnt - ONE_CNT;
        end

        // run of ones on the incoming stream
        next_ones_cnt = ones_cnt;
        if (rx_bit_valid_i) begin
            if (!rx_bit_i) begin
                next_ones_cnt = 3'h0;
            end else if (ones_cnt != `HSU_ABORT_ONES) begin
                next_ones_cnt = ones_cnt + 3'h1;                         // R10
            end
        end

        // packet tracking for opening byte and packet ok tags
        next_pend_first = pend_first;
        next_pkt_bad    = pkt_bad;
        if (rx_take) begin
            next_pend_first = 1'b0;
        end
        if (rx_opening_i) begin
            next_pend_first = 1'b1;                                      // R17
            next_pkt_bad    = 1'b0;
        end
        if (ev_ovr || ev_abort) begin
            next_pkt_bad = 1'b1;                                         // R15
        end

        // read data for the host
        next_rdata = `HSU_BYTE_ZERO;
        case (addr_i)
            `HSU_ADDR_STATUS: next_rdata = stat_view;
            `HSU_ADDR_MASK:   next_rdata = mask;
            `HSU_ADDR_INFO:   next_rdata = info_view;
            default:          next_rdata = `HSU_BYTE_ZERO;
        endcase
        if (!rd_i) begin
            next_rdata = rdata_o;
        end

        // interrupt from the state that will hold next cycle
        next_int_n = ~|(status_of(next_lat_stat, next_rx_cnt, next_tx_cnt)
                        & next_mask);                                    // R19 R20
    end

    // ==========================================================
    // registers
    always_ff @(posedge clock_i) begin
        if (rst_i) begin
            lat_stat   <= `HSU_BYTE_ZERO;
            lat_info   <= `HSU_BYTE_ZERO;
            mask       <= `HSU_MASK_RESET;
            rx_cnt     <= '0;
            tx_cnt     <= '0;
            rx_wr_ptr  <= '0;
            rx_rd_ptr  <= '0;
            ones_cnt   <= 3'h0;
            pend_first <= 1'b0;
            pkt_bad    <= 1'b0;
            rdata_o    <= `HSU_BYTE_ZERO;
            int_n_o    <= 1'b1;
        end else begin
            lat_stat   <= next_lat_stat;
            lat_info   <= next_lat_info;
            mask       <= next_mask;
            rx_cnt     <= next_rx_cnt;
            tx_cnt     <= next_tx_cnt;
            rx_wr_ptr  <= next_rx_wr_ptr;
            rx_rd_ptr  <= next_rx_rd_ptr;
            ones_cnt   <= next_ones_cnt;
            pend_first <= next_pend_first;
            pkt_bad    <= next_pkt_bad;
            rdata_o    <= next_rdata;
            int_n_o    <= next_int_n;
        end
    end

endmodule

`default_nettype wire

// ### hsu_status_properties.sv
// concurrent checks on the packet status unit's ports
`timescale 1ns/1ns
`default_nettype none
`include "hsu_map.svh"

module hsu_status_properties #(
    parameter int DEPTH = `HSU_FIFO_DEPTH
) (
    // clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    // control port
    input  wire logic [7:0] addr_i,
    input  wire logic       wr_i,
    input  wire logic       rd_i,
    input  wire logic [7:0] wdata_i,
    input  wire logic [7:0] rdata_o,
    input  wire logic       int_n_o,
    // packet controller events
    input  wire logic       rx_opening_i,
    input  wire logic       rx_push_i,
    input  wire logic       rx_push_last_i,
    input  wire logic       rx_crc_match_i,
    input  wire logic       tx_msg_done_i
);
    logic       rd_status;   // status read taken
    logic       rd_info;     // info read taken
    logic       rd_mask;     // mask read taken
    logic       mask_wr;     // mask write taken
    logic [7:0] mask_q;      // shadow of the mask register
    logic [7:0] next_mask_q; // shadow next value

    assign rd_status = rd_i && (addr_i == `HSU_ADDR_STATUS);
    assign rd_info   = rd_i && (addr_i == `HSU_ADDR_INFO);
    assign rd_mask   = rd_i && (addr_i == `HSU_ADDR_MASK);
    assign mask_wr   = wr_i && (addr_i == `HSU_ADDR_MASK);

    // ==========================================
    // mask shadow, follows host writes
    always_comb begin
        next_mask_q = mask_q;
        if (rst_i) begin
            next_mask_q = `HSU_MASK_RESET;
        end else if (mask_wr) begin
            next_mask_q = wdata_i & `HSU_MASK_USED;
        end
    end

    always_ff @(posedge clock_i) begin
        mask_q <= next_mask_q;
    end

    // ==========================================
    // properties
    default clocking cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    reset_idle_a: assert property (disable iff (1'b0) rst_i |=> int_n_o && rdata_o == 8'h00)
        else $error("outputs not idle after reset");
    unmapped_read_a: assert property (rd_i && !(addr_i inside {8'hB1, 8'hB2, 8'hB3})
        |=> rdata_o == 8'h00) else $error("unmapped read not zero");
    read_hold_a: assert property (!rd_i |=> $stable(rdata_o))
        else $error("read data moved without a read");
    mask_readback_a: assert property (rd_mask |=> rdata_o == $past(mask_q))
        else $error("mask readback wrong");
    start_flag_a: assert property (rx_opening_i ##1 !rd_status ##1 rd_status
        |=> rdata_o[5]) else $error("packet start flag missing");
    end_flag_a: assert property (rx_push_i && rx_push_last_i ##1 !rd_status ##1 rd_status
        |=> rdata_o[6]) else $error("packet end flag missing");
    crc_flag_a: assert property (rx_push_i && rx_push_last_i && !rx_crc_match_i
        ##1 !rd_info ##1 rd_info |=> rdata_o[6]) else $error("crc error flag missing");
    read_clear_a: assert property (rd_status && !tx_msg_done_i ##1 !tx_msg_done_i
        ##1 rd_status && !tx_msg_done_i |=> !rdata_o[0]) else $error("message end not cleared");
    event_irq_a: assert property ((tx_msg_done_i && mask_q[0] || rx_opening_i && mask_q[5])
        && !mask_wr |=> !int_n_o) else $error("interrupt not raised");
    irq_quiet_a: assert property (mask_q == 8'h00 && !mask_wr |=> int_n_o)
        else $error("interrupt raised while all masked");
endmodule

bind hsu_status_unit hsu_status_properties #(.DEPTH(DEPTH)) u_props (
    .clock_i        (clock_i),
    .rst_i          (rst_i),
    .addr_i         (addr_i),
    .wr_i           (wr_i),
    .rd_i           (rd_i),
    .wdata_i        (wdata_i),
    .rdata_o        (rdata_o),
    .int_n_o        (int_n_o),
    .rx_opening_i   (rx_opening_i),
    .rx_push_i      (rx_push_i),
    .rx_push_last_i (rx_push_last_i),
    .rx_crc_match_i (rx_crc_match_i),
    .tx_msg_done_i  (tx_msg_done_i)
);

`default_nettype wire

// ### hsu_host_model.sv
// host model driving the parallel control port
`timescale 1ns/1ns
`default_nettype none

module hsu_host_model (
    // clock
    input  wire logic       clock_i,
    // control port toward the unit
    output var logic  [7:0] addr_o,
    output var logic        wr_o,
    output var logic        rd_o,
    output var logic  [7:0] wdata_o,
    input  wire logic [7:0] rdata_i
);
    // idle port at time zero
    initial begin
        addr_o = 8'h00;
        wr_o = 1'b0;
        rd_o = 1'b0;
        wdata_o = 8'h00;
    end

    // one write, taken at the next edge, then an idle cycle
    task automatic write_reg(input logic [7:0] a, input logic [7:0] d);
        addr_o = a;
        wdata_o = d;
        wr_o = 1'b1;
        @(posedge clock_i);
        #1 wr_o = 1'b0;
        wdata_o = ~d;  // released data does not keep its value
        @(posedge clock_i);
        #1;
    endtask

    // one read; also how the host acknowledges the interrupting event
    task automatic read_reg(input logic [7:0] a, output logic [7:0] d);
        addr_o = a;
        rd_o = 1'b1;
        @(posedge clock_i);
        #1 rd_o = 1'b0;
        d = rdata_i;
        @(posedge clock_i);
        #1;
    endtask
endmodule

`default_nettype wire

// ### hsu_status_unit_test.sv
// self-checking bench for the packet status unit
`timescale 1ns/1ns
`default_nettype none
`include "hsu_map.svh"

module hsu_status_unit_test;
    // event strobes packed into ev
    localparam logic [7:0] OPN = 8'h80, PSH = 8'h40, LST = 8'h20, MAT = 8'h10;
    localparam logic [7:0] POP = 8'h08, TPU = 8'h04, TPO = 8'h02, TMD = 8'h01;
    localparam logic [7:0] ST = `HSU_ADDR_STATUS, MK = `HSU_ADDR_MASK, IN = `HSU_ADDR_INFO;
    localparam int LIMIT = 4000;  // cycle ceiling

    logic       clock_i = 1'b0; // 25 MHz
    logic       rst_i   = 1'b1; // sync reset
    logic [7:0] addr_i;         // host port
    logic       wr_i;
    logic       rd_i;
    logic [7:0] wdata_i;
    logic [7:0] rdata_o;
    logic       int_n_o;
    logic       rx_bit  = 1'b0; // stream bit
    logic       rx_bv   = 1'b0; // stream bit valid
    logic [7:0] ev      = 8'h00;
    int         n_mismatch = 0;
    int         checks_done = 0;
    int         cycles = 0;

    always #20 clock_i = ~clock_i;

    hsu_host_model u_host (.clock_i(clock_i), .addr_o(addr_i), .wr_o(wr_i), .rd_o(rd_i),
        .wdata_o(wdata_i), .rdata_i(rdata_o));

    hsu_status_unit u_hsu_status_unit (.clock_i(clock_i), .rst_i(rst_i), .addr_i(addr_i),
        .wr_i(wr_i), .rd_i(rd_i), .wdata_i(wdata_i), .rdata_o(rdata_o), .int_n_o(int_n_o),
        .rx_bit_i(rx_bit), .rx_bit_valid_i(rx_bv), .rx_opening_i(ev[7]), .rx_push_i(ev[6]),
        .rx_push_last_i(ev[5]), .rx_crc_match_i(ev[4]), .rx_pop_i(ev[3]), .tx_push_i(ev[2]),
        .tx_pop_i(ev[1]), .tx_msg_done_i(ev[0]));

    // compare and count
    task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
        checks_done++;
        if (got !== exp) begin
            n_mismatch++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
        logic [7:0] d;
        u_host.read_reg(a, d);
        chk($sformatf("reg %h", a), exp, d);
    endtask

    task automatic int_chk(input logic exp);
        chk("int_n", {7'h00, exp}, {7'h00, int_n_o});
    endtask

    // n back-to-back event cycles, then an idle cycle
    task automatic pulse(input logic [7:0] v, input int n);
        ev = v;
        repeat (n) @(posedge clock_i);
        #1 ev = 8'h00;
        @(posedge clock_i);
        #1;
    endtask

    // n ones then a zero on the stream
    task automatic ones(input int n);
        rx_bv = 1'b1;
        rx_bit = 1'b1;
        repeat (n) @(posedge clock_i);
        #1 rx_bit = 1'b0;
        @(posedge clock_i);
        #1 rx_bv = 1'b0;
    endtask

    task automatic end_sim;
        $display("checks %0d mismatches %0d", checks_done, n_mismatch);
        if (n_mismatch == 0 && checks_done > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    // hang guard
    always @(posedge clock_i) begin
        cycles++;
        if (cycles == LIMIT) begin
            n_mismatch++;
            end_sim();
        end
    end

    initial begin
        repeat (20) @(posedge clock_i);
        #1 rst_i = 1'b0;
        rd_chk(ST, 8'h06);
        rd_chk(IN, 8'h08);
        rd_chk(MK, 8'h00);
        u_host.write_reg(MK, 8'hFF);
        int_chk(1'b0);
        rd_chk(MK, 8'h7F);
        u_host.write_reg(ST, 8'hFF);
        u_host.write_reg(IN, 8'hFF);
        rd_chk(ST, 8'h06);
        rd_chk(8'hB0, 8'h00);
        u_host.write_reg(MK, 8'h00);
        int_chk(1'b1);
        $display("test registers done");
        pulse(OPN, 1);
        pulse(PSH, 2);
        pulse(PSH | LST | MAT, 1);
        rd_chk(ST, 8'h6E);
        rd_chk(ST, 8'h0E);
        rd_chk(IN, 8'h11);
        rd_chk(IN, 8'h01);
        pulse(POP, 1);
        rd_chk(IN, 8'h00);
        pulse(POP, 1);
        rd_chk(IN, 8'h06);
        pulse(POP, 1);
        rd_chk(IN, 8'h08);
        $display("test good packet done");
        pulse(OPN, 1);
        rd_chk(ST, 8'h26);
        pulse(PSH | LST, 1);
        rd_chk(IN, 8'h43);
        rd_chk(ST, 8'h4E);
        rd_chk(IN, 8'h03);
        pulse(POP, 1);
        $display("test crc error done");
        ones(6);
        rd_chk(IN, 8'h08);
        ones(7);
        rd_chk(IN, 8'h88);
        rd_chk(ST, 8'h46);
        $display("test abort done");
        pulse(PSH, 32);
        rd_chk(ST, 8'h0E);
        pulse(PSH, 1);
        rd_chk(ST, 8'h1E);
        pulse(PSH, 32);
        rd_chk(IN, 8'h20);
        rd_chk(ST, 8'h5E);
        pulse(POP, 64);
        rd_chk(IN, 8'h08);
        $display("test overrun done");
        pulse(TPU, 31);
        rd_chk(ST, 8'h06);
        pulse(TPU, 1);
        rd_chk(ST, 8'h02);
        pulse(TPU, 33);
        rd_chk(ST, 8'h00);
        pulse(TPO, 1);
        rd_chk(ST, 8'h02);
        pulse(TMD, 1);
        int_chk(1'b1);
        u_host.write_reg(MK, 8'h01);
        int_chk(1'b0);
        rd_chk(ST, 8'h03);
        int_chk(1'b1);
        rd_chk(ST, 8'h02);
        pulse(TMD, 1);
        int_chk(1'b0);
        rd_chk(ST, 8'h03);
        int_chk(1'b1);
        u_host.write_reg(MK, 8'h02);
        int_chk(1'b0);
        u_host.write_reg(MK, 8'h00);
        int_chk(1'b1);
        $display("test transmit and interrupt done");
        end_sim();
    end
endmodule

`default_nettype wire
